//--- rtl/ocd_pkg.sv
// Package for the internal oscillator and divider block
package ocd_pkg;
   // Divider width: last tap is bit 19 (1-based), index 18
   localparam int OCD_DIV_W = 19;
   // Tap bit positions, 1-based numbering turned to index
   localparam int OCD_TAP0_POS = 3;
   localparam int OCD_TAP1_POS = 8;
   localparam int OCD_TAP2_POS = 13;
   localparam int OCD_TAP3_POS = 18;
   localparam int OCD_NUM_TAPS = 4;
   localparam logic [OCD_DIV_W-1:0] OCD_DIV_RST = 19'h00000;
   // Power-on time-out and memory clear lengths in oscillator cycles
   localparam int OCD_POR_NS = 40000;
   localparam int OCD_CLK_NS = 10;
   localparam int OCD_POR_CYC = (OCD_POR_NS + OCD_CLK_NS - 1) / OCD_CLK_NS;
   localparam int OCD_CLR_CYC = 64;
   localparam logic [15:0] OCD_CNT_RST = 16'h0000;
   localparam logic [1:0] OCD_SEL_RST = 2'h0;

   typedef enum logic [1:0] {
      OCD_ST_POR = 2'b00,
      OCD_ST_CLR = 2'b01,
      OCD_ST_CFG = 2'b11,
      OCD_ST_USR = 2'b10
   } ocd_state_t;

   // Pair of selected user taps
   typedef struct packed {
      logic tap_a;
      logic tap_b;
   } ocd_taps_t;
endpackage

//--- rtl/ocd_tap_sync.sv
// Resynchroniser for one divider tap
`timescale 1ns/1ns
module ocd_tap_sync (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   input wire logic tap_i,
   output logic tap_o
);
   logic tap_d;
   logic tap_q;

   always_comb begin
      tap_d = en_i ? tap_i : 1'b0;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tap_q <= 1'b0;
      end else begin
         tap_q <= tap_d;
      end
   end

   assign tap_o = tap_q;
endmodule // ocd_tap_sync

//--- rtl/ocd_osc_div.sv
// Internal oscillator gate, divider, taps and start-up sequencing
`timescale 1ns/1ns
// What this block does
// - Oscillator times power-on, memory clearing, and drives configuration clock in master modes
// - Divider gives taps at bits four, nine, fourteen, nineteen, each resynchronised
// - User logic picks any two of four taps alongside primary output
// - Oscillator divided by two offered to user logic after configuration completes
// - Oscillator stops after configuration unless the library element is used
module ocd_osc_div
   import ocd_pkg::*;
#(
   parameter int POR_CYC = OCD_POR_CYC
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CFG_DONE_I,
   input wire logic MASTER_MODE_I,
   input wire logic ELEM_USED_I,
   input wire logic [1:0] SEL_A_I,
   input wire logic [1:0] SEL_B_I,
   output logic POR_DONE_O,
   output logic CLR_ACTIVE_O,
   output logic CFG_CLK_O,
   output logic OSC_RUN_O,
   output logic OSC_USER_O,
   output ocd_taps_t TAPS_O
);
   ////////////////////////////////////////////////////////////////
   // Done pin input: three stages, change accepted when stages 2 and 3 agree
   logic [2:0] done_s_q;
   logic [2:0] done_s_d;
   logic done_f_q;
   logic done_f_d;

   always_comb begin
      done_s_d = {done_s_q[1:0], CFG_DONE_I};
      done_f_d = (done_s_q[2] == done_s_q[1]) ? done_s_q[2] : done_f_q;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         done_s_q <= 3'h0;
         done_f_q <= 1'b0;
      end else begin
         done_s_q <= done_s_d;
         done_f_q <= done_f_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Start-up sequence
   ocd_state_t st_q;
   ocd_state_t st_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic run_q;
   logic run_d;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q + 16'h0001;
      run_d = run_q;
      case (st_q)
         OCD_ST_POR: begin
            if (cnt_q == 16'(POR_CYC - 1)) begin
               st_d = OCD_ST_CLR;
               cnt_d = OCD_CNT_RST;
            end
         end
         OCD_ST_CLR: begin
            if (cnt_q == 16'(OCD_CLR_CYC - 1)) begin
               st_d = OCD_ST_CFG;
               cnt_d = OCD_CNT_RST;
            end
         end
         OCD_ST_CFG: begin
            cnt_d = OCD_CNT_RST;
            if (done_f_q) begin
               st_d = OCD_ST_USR;
               // Element sampled once at the end of configuration
               run_d = ELEM_USED_I;
            end
         end
         OCD_ST_USR: begin
            cnt_d = OCD_CNT_RST;
         end
         default: begin
            st_d = OCD_ST_POR;
            cnt_d = OCD_CNT_RST;
         end
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_q <= OCD_ST_POR;
         cnt_q <= OCD_CNT_RST;
         run_q <= 1'b1;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         run_q <= run_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Binary divider; frozen when the oscillator is stopped
   logic [OCD_DIV_W-1:0] div_q;
   logic [OCD_DIV_W-1:0] div_d;
   logic [OCD_NUM_TAPS-1:0] tap_raw;
   logic [OCD_NUM_TAPS-1:0] tap_sync;
   logic user_q;
   logic user_d;

   always_comb begin
      div_d = run_q ? div_q + 19'h00001 : div_q;
      user_d = (st_q == OCD_ST_USR) && run_q;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         div_q <= OCD_DIV_RST;
         user_q <= 1'b0;
      end else begin
         div_q <= div_d;
         user_q <= user_d;
      end
   end

   assign tap_raw = {div_q[OCD_TAP3_POS], div_q[OCD_TAP2_POS], div_q[OCD_TAP1_POS], div_q[OCD_TAP0_POS]};

   genvar gi;
   generate
      for (gi = 0; gi < OCD_NUM_TAPS; gi++) begin : g_tap
         ocd_tap_sync u_sync (
            .clk_i(CLK_I),
            .rst_n_i(RST_N_I),
            .en_i(run_q),
            .tap_i(tap_raw[gi]),
            .tap_o(tap_sync[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // Outputs, all registered
   logic por_done_q;
   logic clr_q;
   logic cfg_clk_q;
   logic osc_user_q;
   ocd_taps_t taps_q;
   ocd_taps_t taps_d;
   logic por_done_d;
   logic clr_d;
   logic cfg_clk_d;
   logic osc_user_d;

   always_comb begin
      por_done_d = (st_q != OCD_ST_POR);
      clr_d = (st_q == OCD_ST_CLR);
      cfg_clk_d = MASTER_MODE_I && (st_q == OCD_ST_CFG) && !cfg_clk_q;
      // Divided by two: a registered output cannot toggle faster
      osc_user_d = user_q && !osc_user_q;
      taps_d.tap_a = user_q && tap_sync[SEL_A_I];
      taps_d.tap_b = user_q && tap_sync[SEL_B_I];
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         por_done_q <= 1'b0;
         clr_q <= 1'b0;
         cfg_clk_q <= 1'b0;
         osc_user_q <= 1'b0;
         taps_q <= '0;
      end else begin
         por_done_q <= por_done_d;
         clr_q <= clr_d;
         cfg_clk_q <= cfg_clk_d;
         osc_user_q <= osc_user_d;
         taps_q <= taps_d;
      end
   end

   assign POR_DONE_O = por_done_q;
   assign CLR_ACTIVE_O = clr_q;
   assign CFG_CLK_O = cfg_clk_q;
   assign OSC_RUN_O = run_q;
   assign OSC_USER_O = osc_user_q;
   assign TAPS_O = taps_q;

   ////////////////////////////////////////////////////////////////
   // Checks
   chk_por_order: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (st_q == OCD_ST_POR) |=> !CLR_ACTIVE_O || (st_q != OCD_ST_POR))
      else $error("clear active during power-on time-out");
   chk_cfg_clk_idle: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      !MASTER_MODE_I ##1 !MASTER_MODE_I |-> !CFG_CLK_O)
      else $error("configuration clock runs outside master mode");
   chk_div_count: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      run_q |=> div_q == $past(div_q) + 19'h00001)
      else $error("divider did not advance");
   chk_tap_follow: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      run_q ##1 run_q |=> tap_sync[0] == $past(div_q[OCD_TAP0_POS]))
      else $error("tap not resynchronised by one edge");
   chk_tap_sel: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      user_q |=> TAPS_O.tap_a == $past(tap_sync[SEL_A_I]) && TAPS_O.tap_b == $past(tap_sync[SEL_B_I]))
      else $error("selected tap mismatch");
   chk_user_toggle: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      user_q ##1 user_q |=> OSC_USER_O != $past(OSC_USER_O))
      else $error("user oscillator output not toggling");
   chk_auto_stop: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (st_q == OCD_ST_CFG && done_f_q && !ELEM_USED_I) |=> !OSC_RUN_O ##1 !OSC_RUN_O)
      else $error("oscillator not stopped without element");
   chk_keep_run: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (st_q != OCD_ST_USR) |-> OSC_RUN_O)
      else $error("oscillator stopped before configuration end");
endmodule // ocd_osc_div

//--- tb/tb_internal_osc_clock_divider.sv
// Self-checking bench for the oscillator, divider and tap block
`timescale 1ns/1ns
module tb_internal_osc_clock_divider;
   import ocd_pkg::*;
   localparam int POR_SIM = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cfg_done = 1'b0;
   logic master = 1'b1;
   logic elem = 1'b1;
   logic [1:0] sel_a = 2'h0;
   logic [1:0] sel_b = 2'h0;
   logic por_done;
   logic clr_act;
   logic cfg_clk;
   logic osc_run;
   logic osc_user;
   ocd_taps_t taps;
   int n_mismatch = 0;
   int checks = 0;

   always #5 clk = ~clk;

   ocd_osc_div #(.POR_CYC(POR_SIM)) dut (
      .CLK_I(clk), .RST_N_I(rst_n), .CFG_DONE_I(cfg_done), .MASTER_MODE_I(master),
      .ELEM_USED_I(elem), .SEL_A_I(sel_a), .SEL_B_I(sel_b), .POR_DONE_O(por_done),
      .CLR_ACTIVE_O(clr_act), .CFG_CLK_O(cfg_clk), .OSC_RUN_O(osc_run),
      .OSC_USER_O(osc_user), .TAPS_O(taps)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   // Drive shortly after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   function automatic int half_of(input logic [1:0] s);
      case (s)
         2'h0: return 1 << OCD_TAP0_POS;
         2'h1: return 1 << OCD_TAP1_POS;
         2'h2: return 1 << OCD_TAP2_POS;
         default: return 1 << OCD_TAP3_POS;
      endcase
   endfunction

   function automatic logic cur(input bit b);
      return b ? taps.tap_b : taps.tap_a;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic boot(input logic use_elem);
      int n;
      logic prev;
      rst_n = 1'b0;
      cfg_done = 1'b0;
      master = 1'b1;
      elem = use_elem;
      tick(4);
      chk(osc_run === 1'b1 && por_done === 1'b0 && taps === 2'h0, "reset outputs");
      rst_n = 1'b1;
      n = 0;
      while (por_done !== 1'b1 && n < POR_SIM + 10) begin
         tick(1);
         n++;
      end
      chk(n >= POR_SIM && n <= POR_SIM + 2, "power-on length");
      n = 0;
      while (clr_act !== 1'b1 && n < 4) begin
         tick(1);
         n++;
      end
      n = 0;
      while (clr_act === 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      chk(n === OCD_CLR_CYC, "clear length");
      tick(2);
      for (int i = 0; i < 6; i++) begin
         prev = cfg_clk;
         tick(1);
         chk(cfg_clk === ~prev, "config clock toggle");
      end
      master = 1'b0;
      tick(3);
      chk(cfg_clk === 1'b0 && osc_user === 1'b0 && taps === 2'h0, "slave idle");
      cfg_done = 1'b1;
      // Sync plus state change plus output register
      tick(8);
      chk(osc_run === use_elem && cfg_clk === 1'b0, "after config");
   endtask

   task automatic measure(input bit b);
      int h;
      int n;
      logic prev;
      h = half_of(b ? sel_b : sel_a);
      // Let the select change pass the output register first
      tick(4);
      if (h == half_of(2'h3)) begin
         // Top tap needs far longer than the run to toggle, so it must stay low
         prev = cur(b);
         tick(64);
         chk(prev === 1'b0 && cur(b) === 1'b0, "top tap held low");
      end else begin
         for (int k = 0; k < 2; k++) begin
            prev = cur(b);
            n = 0;
            while (cur(b) === prev && n < 2 * h + 8) begin
               tick(1);
               n++;
            end
         end
         chk(n === h, "tap half period");
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic prev;
      void'($urandom(32'hD1E5F960));
      boot(1'b1);
      for (int i = 0; i < 4; i++) begin
         prev = osc_user;
         tick(1);
         chk(osc_user === ~prev, "user clock toggle");
      end
      $display("test startup done");
      sel_a = 2'h2;
      sel_b = 2'h0;
      measure(1'b0);
      measure(1'b1);
      repeat (3) begin
         sel_a = 2'($urandom_range(1, 0));
         sel_b = 2'($urandom_range(1, 0));
         measure(1'b0);
         measure(1'b1);
      end
      sel_a = 2'h3;
      sel_b = 2'h1;
      measure(1'b0);
      measure(1'b1);
      $display("test taps done");
      boot(1'b0);
      tick(300);
      chk(osc_run === 1'b0 && osc_user === 1'b0 && taps === 2'h0, "oscillator stopped");
      $display("test stop done");
      conclude();
   end

   initial begin
      // Roughly three times the expected run of about 21000 cycles
      #600000;
      n_mismatch++;
      $display("wrong value at %0t: watchdog", $time);
      conclude();
   end
endmodule // tb_internal_osc_clock_divider
